/* biquad_eq_and_level_control_tb.sv */
// self-checking bench for the band filter / level stage: apb master, stream model, scenarios
// assumes short sample counts (8) for zero-cross timeout and recovery wait
`include "bqalc_cfg.svh"
module biquad_eq_and_level_control_tb import bqalc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire limiting;
  bqalc_sample_t s_in;
  bqalc_sample_t s_out;
  int n_fail = 0;
  int checks = 0;
  bqalc_pcm_t above [4] = '{24'sh610000, 24'sh510000, 24'sh410000, 24'sh310000};
  bqalc_pcm_t below [4] = '{24'sh5f0000, 24'sh4f0000, 24'sh3f0000, 24'sh2f0000};
  // 250 mhz core clock
  always #2 clk = ~clk;
  bqalc_top #(.ZC_BASE(8), .WAIT_BASE(8)) i_dut (
    .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAMPLE_IN(s_in), .SAMPLE_OUT(s_out), .LIMITING(limiting));
  bqalc_stream_model i_mdl (.clk(clk), .sample_out(s_in), .sample_in(s_out));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer; the request holds until pready is seen high, then an idle cycle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, exp_err}, "slave error");
  endtask : rd
  // send one stereo sample and wait, bounded, for its processed result
  task automatic smp(input bqalc_pcm_t l, input bqalc_pcm_t r);
    int n0;
    int k;
    n0 = i_mdl.got_count;
    i_mdl.put(l, r);
    k = 0;
    while (i_mdl.got_count == n0 && k < 8) begin
      @(posedge clk);
      k++;
    end
    if (k >= 8) begin
      n_fail++;
      summarize();
    end
    repeat (2) @(posedge clk);
  endtask : smp
  // internal gains and limiting flag as the status word shows them; fast flag expected clear
  task automatic gains(input logic [7:0] g, input logic lim);
    rd(`BQ_ADDR_STAT, {15'h0, lim, g, g}, 1'b0);
    chk({31'h0, limiting}, {31'h0, lim}, "limiting pin");
  endtask : gains
  task automatic t_reset();
    rd(`BQ_ADDR_CTRL, 32'h0, 1'b0);
    rd(`BQ_ADDR_ALC, 32'h00f10000, 1'b0);
    rd(`BQ_ADDR_GAIN, 32'h0000f1f1, 1'b0);
    rd(`BQ_ADDR_STAT, 32'h0000f1f1, 1'b0);
    rd(8'h4c, 32'h0, 1'b1);
    rd(8'h01, 32'h0, 1'b1);
    smp(24'sh123456, 24'sh123456);
    chk(32'(i_mdl.got_left), 32'h0, "powered down output");
    $display("test reset done");
  endtask : t_reset
  task automatic t_unity();
    wr(`BQ_ADDR_CTRL, 32'h400);
    wr(`BQ_ADDR_GAIN, 32'h9191);
    smp(24'sh0, 24'sh0);
    gains(8'h91, 1'b0);
    smp(24'sh123456, -24'sh1000);
    chk(32'(i_mdl.got_left), 32'(24'sh123456), "unity left");
    chk(32'(i_mdl.got_right), 32'(-24'sh1000), "unity right");
    $display("test unity done");
  endtask : t_unity
  // coefficients 1.0, 0.5, -0.5 in steps of two to the minus thirteen; band stays stable
  task automatic t_bands();
    bqalc_pcm_t exp [3] = '{24'sh2000, 24'sh2800, 24'sh1400};
    for (int b = 0; b < 5; b++) begin
      // power down first: it clears every history, so each band starts from silence
      wr(`BQ_ADDR_CTRL, 32'h0);
      wr(8'(8'h10 + 12 * b), 32'h2000);
      wr(8'(8'h14 + 12 * b), 32'h1000);
      wr(8'(8'h18 + 12 * b), 32'hf000);
      rd(8'(8'h18 + 12 * b), 32'h0000f000, 1'b0);
      wr(`BQ_ADDR_CTRL, 32'h400 | (32'h1 << b));
      for (int n = 0; n < 3; n++) begin
        smp(24'sh1000, -24'sh1000);
        chk(32'(i_mdl.got_left), 32'(exp[n]), "band left");
        chk(32'(i_mdl.got_right), 32'(-exp[n]), "band right");
      end
      wr(`BQ_ADDR_CTRL, 32'h400);
    end
    $display("test bands done");
  endtask : t_bands
  // zero-cross off: every threshold code, step forced to one, manual writes dropped
  task automatic t_limit();
    for (int c = 0; c < 4; c++) begin
      wr(`BQ_ADDR_ALC, 32'h910000 | 32'(c) | (32'(c) << 2));
      wr(`BQ_ADDR_CTRL, 32'h700);
      smp(below[c], 24'sh0);
      gains(8'h91, 1'b0);
      // the shared gain drops at the limiting sample, the channels take it at the next one
      smp(c[0] ? 24'sh0 : above[c], c[0] ? above[c] : 24'sh0);
      gains(8'h91, 1'b1);
      smp(24'sh0, 24'sh0);
      gains(8'h90, 1'b0);
      wr(`BQ_ADDR_GAIN, 32'h4040);
      rd(`BQ_ADDR_GAIN, 32'h9191, 1'b0);
      wr(`BQ_ADDR_CTRL, 32'h600);
      smp(24'sh0, 24'sh0);
      gains(8'h91, 1'b0);
    end
    $display("test limit done");
  endtask : t_limit
  // zero-cross on: the step waits for a crossing, every attenuation code
  task automatic t_zc();
    logic [7:0] st [4] = '{8'h1, 8'h2, 8'h2, 8'h1};
    for (int a = 0; a < 4; a++) begin
      wr(`BQ_ADDR_ALC, 32'h910000 | (32'(a) << 2));
      wr(`BQ_ADDR_CTRL, 32'h500);
      smp(24'sh100, 24'sh100);
      smp(24'sh610000, 24'sh610000);
      gains(8'h91, 1'b1);
      smp(24'sh100, 24'sh100);
      gains(8'h91, 1'b0);
      // odd codes take the step at a crossing, even codes only at the timeout
      for (int n = 0; n < (a[0] ? 1 : 7); n++)
        smp(a[0] ? -24'sh100 : 24'sh100, a[0] ? -24'sh100 : 24'sh100);
      gains(8'h91 - st[a], 1'b0);
      wr(`BQ_ADDR_CTRL, 32'h400);
      smp(24'sh0, 24'sh0);
    end
    $display("test zero cross done");
  endtask : t_zc
  // recovery after the wait, capped at the reference, then a fresh limit
  task automatic t_recover();
    wr(`BQ_ADDR_ALC, 32'h910200);
    wr(`BQ_ADDR_CTRL, 32'h700);
    smp(24'sh610000, 24'sh0);
    gains(8'h91, 1'b1);
    for (int n = 0; n < 4; n++) smp(n[0] ? 24'sh1000 : -24'sh1000, 24'sh1000);
    gains(8'h90, 1'b0);
    for (int n = 0; n < 40; n++) smp(n[0] ? 24'sh1000 : -24'sh1000, 24'sh1000);
    gains(8'h91, 1'b0);
    smp(24'sh610000, 24'sh0);
    gains(8'h91, 1'b1);
    smp(24'sh1000, 24'sh1000);
    gains(8'h90, 1'b0);
    wr(`BQ_ADDR_CTRL, 32'h400);
    $display("test recovery done");
  endtask : t_recover
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_unity();
    t_bands();
    t_limit();
    t_zc();
    t_recover();
    summarize();
  end
endmodule : biquad_eq_and_level_control_tb

/* bqalc_cfg.svh */
// register map, field positions, reset values and sample counts of the band filter / level stage
// assumes byte addressing on a 32-bit apb bus, one aligned word per register
`ifndef BQALC_CFG_SVH
`define BQALC_CFG_SVH
`define BQ_ADDR_CTRL 8'h00
`define BQ_ADDR_ALC 8'h04
`define BQ_ADDR_GAIN 8'h08
`define BQ_ADDR_STAT 8'h0c
`define BQ_ADDR_COEF 8'h10
`define BQ_COEF_WORDS 15
`define BQ_COEF_FRAC 13
`define BQ_GAIN_FRAC 14
`define BQ_CTRL_AUTO 8
`define BQ_CTRL_ZCD 9
`define BQ_CTRL_PWR 10
`define BQ_CTRL_MASK 32'h0000071f
`define BQ_ALC_MASK 32'h00ff1fff
`define BQ_CTRL_RESET 32'h00000000
`define BQ_ALC_RESET 32'h00f10000
`define BQ_GAIN_RESET 16'hf1f1
`define BQ_GAIN_UNITY 10'sh091
`define BQ_ZC_BASE 128
`define BQ_WAIT_BASE 128
`endif

/* bqalc_pkg.sv */
// types shared by the band filter / level stage and its surroundings
// assumes 24-bit signed pcm samples on a single core clock
package bqalc_pkg;
  typedef logic signed [23:0] bqalc_pcm_t;
  typedef logic signed [15:0] bqalc_coef_t;
  // one stereo sample, valid pulses once per sample period
  typedef struct packed {
    logic valid;
    bqalc_pcm_t left;
    bqalc_pcm_t right;
  } bqalc_sample_t;
  typedef enum {BQALC_MANUAL, BQALC_LIMIT, BQALC_RECOVER} bqalc_state_t;
endpackage : bqalc_pkg

/* bqalc_stream_model.sv */
// upstream sample source and downstream sink around the band filter / level stage
// assumes one core clock; the caller spaces the samples, one valid pulse each
module bqalc_stream_model import bqalc_pkg::*; (
  // clock
  input wire logic clk,
  // stream towards and from the stage
  output bqalc_sample_t sample_out,
  input wire bqalc_sample_t sample_in
);
  timeunit 1ns;
  timeprecision 1ps;
  bqalc_pcm_t got_left;
  bqalc_pcm_t got_right;
  int got_count = 0;
  initial sample_out = '0;
  // keep each processed sample at the edge where its valid pulse shows
  always @(posedge clk) begin
    if (sample_in.valid === 1'b1) begin
      got_left <= sample_in.left;
      got_right <= sample_in.right;
      got_count <= got_count + 1;
    end
  end
  // one valid pulse; the data then turns to its inverse so stale bits never pass as a sample
  task automatic put(input bqalc_pcm_t l, input bqalc_pcm_t r);
    @(posedge clk);
    sample_out <= '{1'b1, l, r};
    @(posedge clk);
    sample_out <= '{1'b0, ~l, ~r};
  endtask : put
endmodule : bqalc_stream_model

/* bqalc_top.sv */
// five switchable band filters followed by the automatic level control with limiter and recovery
// assumes upstream drives one valid pulse per sample on CORE_CLK; apb master per the bus spec
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`include "bqalc_cfg.svh"
module bqalc_top import bqalc_pkg::*; #(
  parameter int ZC_BASE = `BQ_ZC_BASE,
  parameter int WAIT_BASE = `BQ_WAIT_BASE
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // sample stream
  input wire bqalc_sample_t SAMPLE_IN,
  output bqalc_sample_t SAMPLE_OUT,
  // status
  output logic LIMITING
);
  localparam logic signed [47:0] FS_MAX = 48'sh7fffff;
  localparam logic signed [47:0] FS_MIN = -48'sh800000;
  // two to the k/16 in q14: one code is 0.375dB, sixteen codes are one octave
  localparam logic [15:0] MANT [16] = '{16'h4000, 16'h42d5, 16'h45cb, 16'h48e2, 16'h4c1c,
    16'h4f7b, 16'h52ff, 16'h56ac, 16'h5a82, 16'h5e84, 16'h62b4, 16'h6712, 16'h6ba2,
    16'h7066, 16'h7560, 16'h7a93};

  function automatic bqalc_pcm_t sat24(input logic signed [47:0] v);
    if (v > FS_MAX) sat24 = 24'sh7fffff;
    else if (v < FS_MIN) sat24 = -24'sh800000;
    else sat24 = v[23:0];
  endfunction : sat24

  // gain code to linear: 91h is 0dB, 00h mutes
  function automatic logic signed [47:0] apply_gain(input bqalc_pcm_t s, input logic [7:0] g);
    logic signed [9:0] d;
    logic signed [5:0] e;
    logic signed [47:0] p;
    d = $signed({2'b00, g}) - `BQ_GAIN_UNITY;
    e = 6'(d >>> 4);
    p = 48'(s) * $signed({1'b0, MANT[d[3:0]]});
    if (g == 8'h00) apply_gain = '0;
    else if (e >= 0) apply_gain = (p <<< e) >>> `BQ_GAIN_FRAC;
    else apply_gain = p >>> (`BQ_GAIN_FRAC - e);
  endfunction : apply_gain

  // linear magnitudes of -2.5, -4.1, -6.0, -8.5 and -12 dBfs
  function automatic logic signed [47:0] level_of(input logic [2:0] i);
    case (i)
      3'h0: level_of = 48'sh5ffc88;
      3'h1: level_of = 48'sh4fd5f8;
      3'h2: level_of = 48'sh40271d;
      3'h3: level_of = 48'sh301b54;
      default: level_of = 48'sh2026ec;
    endcase
  endfunction : level_of

  // register file
  logic [31:0] ctrl_reg;
  logic [31:0] alc_reg;
  logic [15:0] gain_reg;
  bqalc_coef_t coef_reg [`BQ_COEF_WORDS];
  logic [31:0] rdata_reg;

  // sample path state
  bqalc_pcm_t x1_reg [2];
  bqalc_pcm_t x2_reg [2];
  bqalc_pcm_t y1_reg [2][5];
  bqalc_pcm_t y2_reg [2][5];
  bqalc_pcm_t band_now [2][5];
  bqalc_pcm_t eq_now [2];
  bqalc_pcm_t chan_x [2];
  logic signed [47:0] wet [2];
  logic signed [47:0] mag [2];
  bqalc_sample_t out_reg;

  // level control state
  bqalc_state_t state_reg, state_next;
  logic [7:0] level_volume_value_reg, level_volume_value_next;
  logic [7:0] iv_reg [2];
  logic [7:0] iv_next [2];
  logic [7:0] target [2];
  logic [10:0] zc_cnt_reg [2];
  logic [10:0] zc_cnt_next [2];
  logic [15:0] wait_cnt_reg, wait_cnt_next;
  logic fast_reg, fast_next;
  logic [1:0] prev_sign_reg;
  logic [1:0] zc_now;

  // bus decode
  wire access = PSEL & PENABLE;
  wire wr_en = access & PWRITE;
  wire aligned = PADDR[1:0] == 2'b00;
  wire hit_ctrl = aligned & (PADDR == `BQ_ADDR_CTRL);
  wire hit_alc = aligned & (PADDR == `BQ_ADDR_ALC);
  wire hit_gain = aligned & (PADDR == `BQ_ADDR_GAIN);
  wire hit_stat = aligned & (PADDR == `BQ_ADDR_STAT);
  wire hit_coef = aligned & (PADDR >= `BQ_ADDR_COEF) &
    (PADDR < 8'(`BQ_ADDR_COEF + 4 * `BQ_COEF_WORDS));
  wire mapped = hit_ctrl | hit_alc | hit_gain | hit_stat | hit_coef;
  wire [5:0] coef_word = PADDR[7:2] - 6'(`BQ_ADDR_COEF >> 2);
  wire [3:0] coef_idx = coef_word[3:0];
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = rdata_reg;

  // control fields
  wire [4:0] band_enable = ctrl_reg[4:0];
  wire auto_level_enable = ctrl_reg[`BQ_CTRL_AUTO];
  wire zero_cross_disable = ctrl_reg[`BQ_CTRL_ZCD];
  wire converter_power_up = ctrl_reg[`BQ_CTRL_PWR];
  wire [1:0] limit_threshold_sel = alc_reg[1:0];
  wire [1:0] limit_atten_step_sel = alc_reg[3:2];
  wire [1:0] zero_cross_timeout_sel = alc_reg[5:4];
  wire [2:0] recovery_wait_sel = alc_reg[8:6];
  wire [1:0] recovery_step_sel = alc_reg[10:9];
  wire [1:0] fast_recovery_speed = alc_reg[12:11];
  wire [7:0] recovery_reference_gain = alc_reg[23:16];
  wire [7:0] level_gain_left = gain_reg[7:0];
  wire [7:0] level_gain_right = gain_reg[15:8];
  wire [7:0] internal_gain_left = iv_reg[0];
  wire [7:0] internal_gain_right = iv_reg[1];
  wire [31:0] status_word = {14'h0, fast_reg, LIMITING, internal_gain_right, internal_gain_left};

  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg : hit_alc ? alc_reg : hit_gain ? {16'h0, gain_reg} :
    hit_stat ? status_word : hit_coef ? {16'h0, coef_reg[coef_idx]} : 32'h0;

  // registers take writes only in the access phase; read data is latched in setup
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= `BQ_CTRL_RESET;
      alc_reg <= `BQ_ALC_RESET;
      gain_reg <= `BQ_GAIN_RESET;
      rdata_reg <= 32'h0;
      for (int i = 0; i < `BQ_COEF_WORDS; i++) coef_reg[i] <= 16'sh0000;
    end else begin
      if (PSEL & ~PENABLE) rdata_reg <= rd_mux;
      if (wr_en & hit_ctrl) ctrl_reg <= PWDATA & `BQ_CTRL_MASK;
      if (wr_en & hit_alc) alc_reg <= PWDATA & `BQ_ALC_MASK;
      if (wr_en & hit_gain & ~auto_level_enable) gain_reg <= PWDATA[15:0];
      if (wr_en & hit_coef) coef_reg[coef_idx] <= PWDATA[15:0];
    end
  end

  // band filters: dry plus every enabled band, coefficients in q13
  assign chan_x[0] = SAMPLE_IN.left;
  assign chan_x[1] = SAMPLE_IN.right;
  always_comb begin
    logic signed [47:0] acc;
    acc = '0;
    for (int ch = 0; ch < 2; ch++) begin
      acc = 48'(chan_x[ch]);
      for (int b = 0; b < 5; b++) begin
        band_now[ch][b] = sat24((48'(coef_reg[b * 3]) * (48'(chan_x[ch]) - 48'(x2_reg[ch]))
          + 48'(coef_reg[b * 3 + 1]) * 48'(y1_reg[ch][b])
          + 48'(coef_reg[b * 3 + 2]) * 48'(y2_reg[ch][b])) >>> `BQ_COEF_FRAC);
        if (band_enable[b]) acc = acc + 48'(band_now[ch][b]);
      end
      eq_now[ch] = sat24(acc);
    end
  end

  // gain stage and level detection on the gained output
  assign wet[0] = apply_gain(eq_now[0], iv_reg[0]);
  assign wet[1] = apply_gain(eq_now[1], iv_reg[1]);
  assign mag[0] = wet[0] < 0 ? -wet[0] : wet[0];
  assign mag[1] = wet[1] < 0 ? -wet[1] : wet[1];
  wire signed [47:0] peak = mag[0] > mag[1] ? mag[0] : mag[1];
  wire signed [47:0] thr_hi = level_of({1'b0, limit_threshold_sel});
  wire signed [47:0] thr_lo = level_of(3'({1'b0, limit_threshold_sel}) + 3'h1);
  wire overfull = auto_level_enable & (peak > FS_MAX);
  wire limit_hit = auto_level_enable & (peak >= thr_hi);
  wire in_band = ~limit_hit & (peak >= thr_lo);
  wire [1:0] atten_steps = (zero_cross_disable | (limit_atten_step_sel == 2'b00) |
    (limit_atten_step_sel == 2'b11)) ? 2'd1 : 2'd2;
  wire [8:0] rise_sum = {1'b0, level_volume_value_reg} + {7'h0, recovery_step_sel} + 9'h001;
  wire [10:0] tmo_len = 11'(ZC_BASE << zero_cross_timeout_sel);
  // fast recovery shortens the wait by 4, 8 or 16; code 11 behaves as 16
  wire [2:0] fast_shift = fast_recovery_speed == 2'b00 ? 3'd2 : fast_recovery_speed == 2'b01 ?
    3'd3 : 3'd4;
  wire [15:0] wait_len = 16'((WAIT_BASE << recovery_wait_sel) >> (fast_reg ? fast_shift : 3'd0));
  wire gains_caught = (iv_reg[0] == level_volume_value_reg) & (iv_reg[1] == level_volume_value_reg);
  assign zc_now[0] = (eq_now[0][23] != prev_sign_reg[0]) | (eq_now[0] == 24'sh0);
  assign zc_now[1] = (eq_now[1][23] != prev_sign_reg[1]) | (eq_now[1] == 24'sh0);
  assign LIMITING = state_reg == BQALC_LIMIT;

  // shared volume: a new step waits until both channels have taken the last one
  always_comb begin
    state_next = state_reg;
    level_volume_value_next = level_volume_value_reg;
    wait_cnt_next = wait_cnt_reg;
    fast_next = fast_reg;
    if (!auto_level_enable) begin
      state_next = BQALC_MANUAL;
      level_volume_value_next = level_gain_left;
      wait_cnt_next = '0;
      fast_next = 1'b0;
    end else if (SAMPLE_IN.valid) begin
      case (state_reg)
        BQALC_MANUAL: state_next = limit_hit ? BQALC_LIMIT : BQALC_RECOVER;
        BQALC_LIMIT: if (!limit_hit) state_next = BQALC_RECOVER;
        default: if (limit_hit) state_next = BQALC_LIMIT;
      endcase
      if (limit_hit) begin
        wait_cnt_next = '0;
        if (gains_caught) begin
          level_volume_value_next = level_volume_value_reg > 8'(atten_steps) ? level_volume_value_reg - 8'(atten_steps) : 8'h01;
          fast_next = overfull;
        end
      end else begin
        if (in_band) wait_cnt_next = '0;
        else if (wait_cnt_reg >= wait_len - 16'h1) begin
          wait_cnt_next = '0;
          if (gains_caught & (level_volume_value_reg < recovery_reference_gain))
            level_volume_value_next = rise_sum > {1'b0, recovery_reference_gain} ?
              recovery_reference_gain : rise_sum[7:0];
        end else wait_cnt_next = wait_cnt_reg + 16'h1;
        if (level_volume_value_reg >= recovery_reference_gain) fast_next = 1'b0;
      end
    end
  end

  // per-channel gains follow at a zero crossing, a timeout or at once
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      target[ch] = auto_level_enable ? level_volume_value_reg : gain_reg[ch * 8 +: 8];
      iv_next[ch] = iv_reg[ch];
      zc_cnt_next[ch] = zc_cnt_reg[ch];
      if (SAMPLE_IN.valid) begin
        if (iv_reg[ch] == target[ch]) zc_cnt_next[ch] = '0;
        else if ((auto_level_enable & zero_cross_disable) | overfull | zc_now[ch] |
          (zc_cnt_reg[ch] >= tmo_len - 11'h1)) begin
          iv_next[ch] = target[ch];
          zc_cnt_next[ch] = '0;
        end else zc_cnt_next[ch] = zc_cnt_reg[ch] + 11'h1;
      end
    end
  end

  // level control flops
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= BQALC_MANUAL;
      level_volume_value_reg <= 8'(`BQ_GAIN_RESET >> 8);
      wait_cnt_reg <= '0;
      fast_reg <= 1'b0;
      iv_reg <= '{8'hf1, 8'hf1};
      zc_cnt_reg <= '{11'h0, 11'h0};
    end else begin
      state_reg <= state_next;
      level_volume_value_reg <= level_volume_value_next;
      wait_cnt_reg <= wait_cnt_next;
      fast_reg <= fast_next;
      iv_reg <= iv_next;
      zc_cnt_reg <= zc_cnt_next;
    end
  end

  // filter histories; power-down clears them so a restart begins from silence
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      x1_reg <= '{24'sh0, 24'sh0};
      x2_reg <= '{24'sh0, 24'sh0};
      y1_reg <= '{default: 24'sh0};
      y2_reg <= '{default: 24'sh0};
      prev_sign_reg <= 2'b00;
    end else if (!converter_power_up) begin
      x1_reg <= '{24'sh0, 24'sh0};
      x2_reg <= '{24'sh0, 24'sh0};
      y1_reg <= '{default: 24'sh0};
      y2_reg <= '{default: 24'sh0};
    end else if (SAMPLE_IN.valid) begin
      for (int ch = 0; ch < 2; ch++) begin
        x1_reg[ch] <= chan_x[ch];
        x2_reg[ch] <= x1_reg[ch];
        prev_sign_reg[ch] <= eq_now[ch][23];
        for (int b = 0; b < 5; b++) begin
          y1_reg[ch][b] <= band_enable[b] ? band_now[ch][b] : 24'sh0;
          y2_reg[ch][b] <= band_enable[b] ? y1_reg[ch][b] : 24'sh0;
        end
      end
    end
  end

  // output sample, one cycle after the input strobe; silent while powered down
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) out_reg <= '0;
    else begin
      out_reg.valid <= SAMPLE_IN.valid;
      if (SAMPLE_IN.valid) begin
        out_reg.left <= converter_power_up ? sat24(wet[0]) : 24'sh0;
        out_reg.right <= converter_power_up ? sat24(wet[1]) : 24'sh0;
      end
    end
  end
  assign SAMPLE_OUT = out_reg;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  a_gain_locked: assert property (wr_en && hit_gain && auto_level_enable |=> $stable(gain_reg))
    else $error("manual gain changed while level control on");
  a_coef_store: assert property (wr_en && hit_coef |=>
    coef_reg[$past(coef_idx)] == $past(PWDATA[15:0]))
    else $error("coefficient write lost");
  a_band_off: assert property (SAMPLE_IN.valid && !band_enable[0] |=> y1_reg[0][0] == 24'sh0)
    else $error("disabled band keeps history");
  a_ref_ceiling: assert property (auto_level_enable && $past(auto_level_enable) &&
    level_volume_value_reg > $past(level_volume_value_reg) |-> level_volume_value_reg <= recovery_reference_gain)
    else $error("recovery above reference");
  a_atten_step: assert property (auto_level_enable && $past(auto_level_enable) &&
    level_volume_value_reg < $past(level_volume_value_reg) && $past(level_volume_value_reg) > 8'h04 |->
    8'($past(level_volume_value_reg) - level_volume_value_reg) == 8'($past(atten_steps)))
    else $error("wrong attenuation step");
  a_zcd_at_once: assert property (SAMPLE_IN.valid && auto_level_enable && zero_cross_disable
    |=> iv_reg[0] == $past(level_volume_value_reg) && iv_reg[1] == $past(level_volume_value_reg))
    else $error("gain not applied within one sample");
  a_overfull_fast: assert property (SAMPLE_IN.valid && overfull |=> iv_reg[1] == $past(target[1]))
    else $error("over full scale gain not applied");
  a_wait_clear: assert property (SAMPLE_IN.valid && auto_level_enable && in_band
    |=> wait_cnt_reg == 16'h0)
    else $error("wait timer not cleared in reset band");
  a_timeout_take: assert property (SAMPLE_IN.valid && zc_cnt_reg[0] >= tmo_len - 11'h1
    |=> iv_reg[0] == $past(target[0]))
    else $error("timeout did not apply gain");
  c_limit: cover property (SAMPLE_IN.valid && limit_hit ##1 level_volume_value_reg < $past(level_volume_value_reg));
  c_recover: cover property (auto_level_enable && level_volume_value_reg > $past(level_volume_value_reg));
  c_band_on: cover property (SAMPLE_IN.valid && band_enable == 5'h1f && eq_now[0] != chan_x[0]);
  c_fast: cover property (fast_reg && level_volume_value_reg > $past(level_volume_value_reg));
endmodule : bqalc_top
